//--- rtl/plm_pkg.sv
// package of offsets, fields, reset values and timing for the power and led control block
package plm_pkg;

  // register offsets on the internal register port
  localparam logic [7:0] PLM_OFS_INSERT = 8'hC2;
  localparam logic [7:0] PLM_OFS_POWER_LED = 8'hC3;
  localparam logic [7:0] PLM_OFS_SLEEP = 8'hC4;
  localparam logic [7:0] PLM_OFS_HOST_SETUP = 8'hC6;

  // field positions in the insertion register
  localparam int PLM_INS_S2_E3 = 2;
  localparam int PLM_INS_S3_E1 = 1;
  localparam int PLM_INS_S3_E2 = 0;
  localparam int PLM_INS_WIDTH = 3;

  // field positions in the power and led register
  localparam int PLM_PWR_CPU_PD = 7;
  localparam int PLM_PWR_CORE_PD = 6;
  localparam int PLM_PWR_LED_HI = 5;
  localparam int PLM_PWR_LED_LO = 4;
  localparam int PLM_PWR_LED_DBG = 3;
  localparam int PLM_PWR_PLL_PD = 2;
  localparam int PLM_PWR_MODE_HI = 1;
  localparam int PLM_PWR_MODE_LO = 0;

  // reset values
  localparam logic [2:0] PLM_RST_INSERT = 3'h0;
  localparam logic [7:0] PLM_RST_POWER_LED = 8'h00;
  localparam logic [7:0] PLM_RST_SLEEP = 8'h50;

  // timing: one sleep unit in ms and the system clock rate
  localparam int PLM_SLEEP_UNIT_MS = 20;
  localparam int PLM_CLK_KHZ = 250000;
  localparam int PLM_SLEEP_UNIT_CYC = PLM_SLEEP_UNIT_MS * PLM_CLK_KHZ;

  // port numbering on the egress tag path
  localparam logic [1:0] PLM_PORT_1 = 2'h1;
  localparam logic [1:0] PLM_PORT_2 = 2'h2;
  localparam logic [1:0] PLM_PORT_3 = 2'h3;

  // power management modes
  typedef enum logic [1:0] {
    PLM_PM_NORMAL = 2'h0,
    PLM_PM_ENERGY_DETECT = 2'h1,
    PLM_PM_SOFT_DOWN = 2'h2,
    PLM_PM_SAVING = 2'h3
  } plm_pm_mode_t;

  // led function encodings
  typedef enum logic [1:0] {
    PLM_LED_LACT_SPEED = 2'h0,
    PLM_LED_LINK_ACTIVITY_INDICATION = 2'h1,
    PLM_LED_LACT_DUPLEX = 2'h2,
    PLM_LED_LINK_DUPLEX = 2'h3
  } plm_led_mode_t;

  // energy detect sleep states, one-hot
  typedef enum logic [1:0] {
    PLM_ED_AWAKE = 2'b01,
    PLM_ED_ASLEEP = 2'b10
  } plm_ed_state_t;

endpackage

//--- rtl/plm_sync.sv
// three flip-flop synchroniser that accepts a change once the last two stages agree
`timescale 1ns/1ps
module plm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } plm_sync_state_t;

  plm_sync_state_t st_r;
  plm_sync_state_t st_nxt;

  if (WIDTH < 1) begin : g_bad_width
    $error("plm_sync width must be at least one");
  end

  // shift chain; the first stage feeds only the second
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.q;

endmodule

//--- rtl/plm_power_led_ctrl.sv
// power management, led function and default vlan insertion control registers
`timescale 1ns/1ps
module plm_power_led_ctrl
  import plm_pkg::*;
#(
  parameter int SLEEP_UNIT_CYC = PLM_SLEEP_UNIT_CYC
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  // internal register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // egress tagging request from the forwarding logic
  input wire logic egress_valid,
  input wire logic [1:0] egress_port,
  input wire logic [1:0] src_port,
  input wire logic frame_tagged,
  output logic insert_pvid,
  output logic insert_valid,
  // link state from the port logic
  input wire logic link_up,
  input wire logic activity,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic device_ready,
  // stretched energy signal from the analog front end
  input wire logic energy_raw,
  // led pins
  output logic indicator_out_a,
  output logic indicator_out_b,
  // power controls
  output logic host_clk_pd_en,
  output logic core_clk_pd_en,
  output logic pll_pd_en,
  output logic [1:0] pm_mode,
  output logic low_power
);

  localparam int UCW = (SLEEP_UNIT_CYC > 1) ? $clog2(SLEEP_UNIT_CYC) : 1;
  localparam logic [UCW-1:0] UNIT_LAST = UCW'(SLEEP_UNIT_CYC - 1);

  if (SLEEP_UNIT_CYC < 1) begin : g_bad_unit
    $error("sleep unit must be at least one clock cycle");
  end

  typedef struct packed {
    // software registers
    logic [PLM_INS_WIDTH-1:0] ins;
    logic [7:0] pwr;
    logic [7:0] sleep;
    // read port
    logic [7:0] rdata;
    logic rvalid;
    // egress tag decision
    logic ins_pvid;
    logic ins_valid;
    // led pins
    logic led_a;
    logic led_b;
    // power outputs
    logic host_pd;
    logic core_pd;
    logic pll_pd;
    logic [1:0] mode;
    logic low_pwr;
    // energy detect sleep machinery
    plm_ed_state_t ed;
    logic [UCW-1:0] unit_cnt;
    logic [7:0] quiet_units;
  } plm_state_t;

  plm_state_t st_r;
  plm_state_t st_nxt;

  logic energy_s;

  // energy arrives from another domain
  plm_sync #(
    .WIDTH(1)
  ) i_plm_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in(energy_raw),
    .sync_out(energy_s)
  );

  // reset image of the whole state
  function automatic plm_state_t plm_reset_state();
    plm_state_t s;
    s = '0;
    s.ins = PLM_RST_INSERT;
    s.pwr = PLM_RST_POWER_LED;
    s.sleep = PLM_RST_SLEEP;
    s.mode = PLM_RST_POWER_LED[PLM_PWR_MODE_HI:PLM_PWR_MODE_LO];
    s.ed = PLM_ED_AWAKE;
    return s;
  endfunction

  // next state
  always_comb begin
    logic link_activity_indication;
    logic [1:0] led_sel;
    logic led_dbg;
    logic quiet_done;
    plm_pm_mode_t mode_cur;
    link_activity_indication = 1'b0;
    led_sel = 2'h0;
    led_dbg = 1'b0;
    quiet_done = 1'b0;
    mode_cur = PLM_PM_NORMAL;
    st_nxt = st_r;

    // register writes; unmapped offsets and bits outside the fields are dropped
    if (reg_wr) begin
      if (reg_addr == PLM_OFS_INSERT) begin
        st_nxt.ins = reg_wdata[PLM_INS_WIDTH-1:0];
      end else if (reg_addr == PLM_OFS_POWER_LED) begin
        st_nxt.pwr = reg_wdata;
      end else if (reg_addr == PLM_OFS_SLEEP) begin
        st_nxt.sleep = reg_wdata;
      end
    end

    // register reads, answered one cycle later
    st_nxt.rvalid = reg_rd;
    if (reg_rd) begin
      if (reg_addr == PLM_OFS_INSERT) begin
        st_nxt.rdata = {{(8 - PLM_INS_WIDTH){1'b0}}, st_r.ins};
      end else if (reg_addr == PLM_OFS_POWER_LED) begin
        st_nxt.rdata = st_r.pwr;
      end else if (reg_addr == PLM_OFS_SLEEP) begin
        st_nxt.rdata = st_r.sleep;
      end else begin
        st_nxt.rdata = 8'h00;
      end
    end

    // power controls follow the stored register one cycle later, two cycles after the write
    st_nxt.host_pd = st_r.pwr[PLM_PWR_CPU_PD];
    st_nxt.core_pd = st_r.pwr[PLM_PWR_CORE_PD];
    st_nxt.pll_pd = st_r.pwr[PLM_PWR_PLL_PD];
    st_nxt.mode = st_r.pwr[PLM_PWR_MODE_HI:PLM_PWR_MODE_LO];
    mode_cur = plm_pm_mode_t'(st_r.pwr[PLM_PWR_MODE_HI:PLM_PWR_MODE_LO]);

    // led function select
    link_activity_indication = link_up & ~activity; // lit on link, blinks off with traffic
    led_sel = st_r.pwr[PLM_PWR_LED_HI:PLM_PWR_LED_LO];
    led_dbg = st_r.pwr[PLM_PWR_LED_DBG];
    if (led_dbg) begin
      st_nxt.led_b = ~energy_s;
      st_nxt.led_a = ~device_ready;
    end else begin
      case (plm_led_mode_t'(led_sel))
        PLM_LED_LACT_SPEED: begin
          st_nxt.led_a = link_activity_indication;
          st_nxt.led_b = speed_100;
        end
        PLM_LED_LINK_ACTIVITY_INDICATION: begin
          st_nxt.led_a = link_up;
          st_nxt.led_b = activity;
        end
        PLM_LED_LACT_DUPLEX: begin
          st_nxt.led_a = link_activity_indication;
          st_nxt.led_b = full_duplex;
        end
        default: begin
          st_nxt.led_a = link_up;
          st_nxt.led_b = full_duplex;
        end
      endcase
    end

    // egress default vlan insertion for untagged frames
    st_nxt.ins_valid = egress_valid;
    st_nxt.ins_pvid = 1'b0;
    if (egress_valid && !frame_tagged) begin
      if (src_port == PLM_PORT_2 && egress_port == PLM_PORT_3) begin
        st_nxt.ins_pvid = st_r.ins[PLM_INS_S2_E3];
      end else if (src_port == PLM_PORT_3 && egress_port == PLM_PORT_1) begin
        st_nxt.ins_pvid = st_r.ins[PLM_INS_S3_E1];
      end else if (src_port == PLM_PORT_3 && egress_port == PLM_PORT_2) begin
        st_nxt.ins_pvid = st_r.ins[PLM_INS_S3_E2];
      end
    end

    // quiet interval: whole 20 ms units without energy
    quiet_done = (st_r.quiet_units >= st_r.sleep);
    if (mode_cur != PLM_PM_ENERGY_DETECT || energy_s) begin
      st_nxt.unit_cnt = '0;
      st_nxt.quiet_units = 8'h00;
    end else if (!quiet_done) begin
      if (st_r.unit_cnt == UNIT_LAST) begin
        st_nxt.unit_cnt = '0;
        st_nxt.quiet_units = st_r.quiet_units + 8'h01;
      end else begin
        st_nxt.unit_cnt = st_r.unit_cnt + UCW'(1);
      end
    end

    // sleep state machine in energy detect mode
    case (st_r.ed)
      PLM_ED_AWAKE: begin
        if (mode_cur == PLM_PM_ENERGY_DETECT && !energy_s && quiet_done) begin
          st_nxt.ed = PLM_ED_ASLEEP;
        end
      end
      PLM_ED_ASLEEP: begin
        if (mode_cur != PLM_PM_ENERGY_DETECT || energy_s) begin
          st_nxt.ed = PLM_ED_AWAKE;
        end
      end
      default: begin
        st_nxt.ed = PLM_ED_AWAKE;
      end
    endcase
    st_nxt.low_pwr = (st_nxt.ed == PLM_ED_ASLEEP);
  end

  // state register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= plm_reset_state();
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign reg_rdata = st_r.rdata;
  assign reg_rvalid = st_r.rvalid;
  assign insert_pvid = st_r.ins_pvid;
  assign insert_valid = st_r.ins_valid;
  assign indicator_out_a = st_r.led_a;
  assign indicator_out_b = st_r.led_b;
  assign host_clk_pd_en = st_r.host_pd;
  assign core_clk_pd_en = st_r.core_pd;
  assign pll_pd_en = st_r.pll_pd;
  assign pm_mode = st_r.mode;
  assign low_power = st_r.low_pwr;

endmodule

//--- tb/plm_power_led_ctrl_sva.sv
// checker of register effects, answers and energy wake
`timescale 1ns/1ps
module plm_power_led_ctrl_sva (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic egress_valid,
  input wire logic frame_tagged,
  input wire logic insert_pvid,
  input wire logic insert_valid,
  input wire logic energy_raw,
  input wire logic host_clk_pd_en,
  input wire logic core_clk_pd_en,
  input wire logic pll_pd_en,
  input wire logic [1:0] pm_mode,
  input wire logic low_power
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic pw;
  // a write to the power and led register
  assign pw = reg_wr && reg_addr == 8'hC3;
  a_host_pd_follow: assert property (pw |-> ##2 host_clk_pd_en == $past(reg_wdata[7], 2))
    else $error("host clock power-down enable wrong");
  a_core_pd_follow: assert property (pw |-> ##2 core_clk_pd_en == $past(reg_wdata[6], 2))
    else $error("core clock power-down enable wrong");
  a_pll_pd_follow: assert property (pw |-> ##2 pll_pd_en == $past(reg_wdata[2], 2))
    else $error("pll power-down enable wrong");
  a_mode_follow: assert property (pw |-> ##2 pm_mode == $past(reg_wdata[1:0], 2))
    else $error("power mode wrong");
  a_read_pulse: assert property (reg_rvalid == $past(reg_rd))
    else $error("read answer pulse wrong");
  a_insert_reserved: assert property (reg_rd && reg_addr == 8'hC2 |=> reg_rdata[7:3] == 5'h00)
    else $error("insertion register upper bits not zero");
  a_egress_answer: assert property (egress_valid |=> insert_valid)
    else $error("egress answer missing");
  a_tagged_keep: assert property (egress_valid && frame_tagged |=> !insert_pvid)
    else $error("tagged frame got insertion");
  a_energy_wake: assert property (energy_raw [*8] |=> !low_power)
    else $error("low power held while energy seen");
  a_sleep_in_ed: assert property ($rose(low_power) |-> pm_mode == 2'h1)
    else $error("low power entered outside energy detect mode");
  c_power_write: cover property (pw ##2 host_clk_pd_en);
  c_sleep_entry: cover property ($rose(low_power));
  c_insert_hit: cover property (insert_valid && insert_pvid);
endmodule
bind plm_power_led_ctrl plm_power_led_ctrl_sva i_plm_power_led_ctrl_sva (
  .clk_sys(clk_sys),
  .reset_n(reset_n),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid),
  .egress_valid(egress_valid),
  .frame_tagged(frame_tagged),
  .insert_pvid(insert_pvid),
  .insert_valid(insert_valid),
  .energy_raw(energy_raw),
  .host_clk_pd_en(host_clk_pd_en),
  .core_clk_pd_en(core_clk_pd_en),
  .pll_pd_en(pll_pd_en),
  .pm_mode(pm_mode),
  .low_power(low_power)
);

//--- tb/plm_power_led_ctrl_bench.sv
// self-checking bench for the power and led control block
`timescale 1ns/1ps
module plm_power_led_ctrl_bench;
  import plm_pkg::*;
  logic clk_sys = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, reg_rvalid;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, d, ins;
  logic egress_valid = 0, frame_tagged = 0, insert_pvid, insert_valid, e, ea, eb;
  logic [1:0] egress_port = 0, src_port = 0, pm_mode;
  logic link_up = 0, activity = 0, speed_100 = 0, full_duplex = 0, device_ready = 0;
  logic energy_raw = 0, indicator_out_a, indicator_out_b;
  logic host_clk_pd_en, core_clk_pd_en, pll_pd_en, low_power;
  logic [7:0] exp_rd[$];
  logic exp_ins[$];
  int n_fail = 0, total_checks = 0;
  plm_power_led_ctrl #(
    .SLEEP_UNIT_CYC(4)
  ) i_plm_power_led_ctrl (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .egress_valid(egress_valid),
    .egress_port(egress_port),
    .src_port(src_port),
    .frame_tagged(frame_tagged),
    .insert_pvid(insert_pvid),
    .insert_valid(insert_valid),
    .link_up(link_up),
    .activity(activity),
    .speed_100(speed_100),
    .full_duplex(full_duplex),
    .device_ready(device_ready),
    .energy_raw(energy_raw),
    .indicator_out_a(indicator_out_a),
    .indicator_out_b(indicator_out_b),
    .host_clk_pd_en(host_clk_pd_en),
    .core_clk_pd_en(core_clk_pd_en),
    .pll_pd_en(pll_pd_en),
    .pm_mode(pm_mode),
    .low_power(low_power)
  );
  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk_byte(logic [7:0] got, logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(logic got, logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  // strobes drop for a cycle between transfers
  task automatic wr(logic [7:0] a, logic [7:0] v);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = v;
    tick();
    reg_wr = 0;
    tick();
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] x);
    reg_rd = 1;
    reg_addr = a;
    exp_rd.push_back(x);
    tick();
    reg_rd = 0;
    tick();
  endtask
  task automatic wait_sleep();
    int n = 0;
    while (low_power !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    chk_bit(low_power, 1'b1);
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // pair each answer with the oldest note, sampled mid-cycle where it stands
  always @(negedge clk_sys) begin
    if (reg_rvalid === 1'b1)
      chk_byte(reg_rdata, exp_rd.size() ? exp_rd.pop_front() : 8'hXX);
    if (insert_valid === 1'b1)
      chk_bit(insert_pvid, exp_ins.size() ? exp_ins.pop_front() : 1'bx);
  end
  // cut a hang short
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    give_verdict();
  end
  // main sequence
  initial begin
    d = 8'($urandom(43));
    tick(16);
    reset_n = 1;
    tick();
    rd(PLM_OFS_INSERT, 8'h00);
    rd(PLM_OFS_POWER_LED, 8'h00);
    rd(PLM_OFS_SLEEP, 8'h50);
    rd(PLM_OFS_HOST_SETUP, 8'h00);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      d[1:0] = 2'(i);
      wr(PLM_OFS_POWER_LED, d);
      chk_bit(host_clk_pd_en, d[7]);
      chk_bit(core_clk_pd_en, d[6]);
      chk_bit(pll_pd_en, d[2]);
      chk_byte({6'h00, pm_mode}, {6'h00, d[1:0]});
      rd(PLM_OFS_POWER_LED, d);
    end
    for (int k = 0; k < 2; k++) begin
      ins = k ? 8'hFF : 8'($urandom);
      wr(PLM_OFS_INSERT, ins);
      rd(PLM_OFS_INSERT, {5'h00, ins[2:0]});
      for (int j = 0; j < 18; j++) begin
        src_port = 2'(j % 3 + 1);
        egress_port = 2'(j / 3 % 3 + 1);
        frame_tagged = j > 8;
        egress_valid = 1;
        e = src_port == 2 && egress_port == 3 && ins[2];
        e = e || src_port == 3 && egress_port == 1 && ins[1];
        e = e || src_port == 3 && egress_port == 2 && ins[0];
        exp_ins.push_back(e && !frame_tagged);
        tick();
      end
      egress_valid = 0;
      tick();
    end
    for (int m = 0; m < 8; m++) begin
      {link_up, activity, speed_100, full_duplex, device_ready, energy_raw} = 6'($urandom);
      wr(PLM_OFS_POWER_LED, {2'h0, 2'(m), m > 3, 3'h0});
      tick(8);
      ea = m[0] ? link_up : link_up & ~activity;
      eb = m[1] ? full_duplex : m[0] ? activity : speed_100;
      chk_bit(indicator_out_a, m > 3 ? ~device_ready : ea);
      chk_bit(indicator_out_b, m > 3 ? ~energy_raw : eb);
    end
    energy_raw = 0;
    wr(PLM_OFS_SLEEP, 8'h03);
    rd(PLM_OFS_SLEEP, 8'h03);
    wr(PLM_OFS_POWER_LED, 8'h01);
    tick(6);
    energy_raw = 1;
    tick(3);
    energy_raw = 0;
    tick(9);
    chk_bit(low_power, 1'b0);
    wait_sleep();
    wr(PLM_OFS_POWER_LED, 8'h00);
    tick(2);
    chk_bit(low_power, 1'b0);
    tick(4);
    chk_byte(8'(exp_rd.size() + exp_ins.size()), 8'h00);
    give_verdict();
  end
endmodule
